// [design/icp_chain_top.sv]
// Operation
// - Pusher number 0 takes only the first pusher after enable and then makes every index itself each division.
// - Pusher number 1 uses every physical pusher edge as the index and ignores the division.
// - Pusher number n resynchronises on one physical pusher per chain cycle and makes the n-1 between from the division.
// - Four cam outputs each have on and off points from 0 to 359.9 degrees, 360 degrees being one division.
// - Zero degrees is where the pusher front edge triggers the pusher sensor.
// - Each cam switches on and off earlier by its own delay time of 0 to 999 ms.
// - Jog moves only the chain, at 0 to 100 percent of maximum chain speed.
// - Jog speed ramps with a time of 0 to 99 s that spans zero to full speed.
// - The signed product offset is added to both the foil offset and the sealing offset.
// - A sensor distance sets how far the product travels from the product sensor to the hand-over point.
// - Product sensor edges within the pusher width after a pusher edge are not taken as products.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module icp_chain_top #(
   parameter int unsigned CYC_PER_MS = icp_pkg::CYC_PER_MS_DEF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // machine pins
   input wire logic enc_step_pin,
   input wire logic pusher_pin,
   input wire logic product_pin,
   input wire logic ctrl_en_pin,
   // cams and events
   output logic [icp_pkg::NUM_CAMS-1:0] cam_out,
   output logic index_pulse,
   output logic virtual_index,
   output logic product_detect,
   output logic handoff_pulse,
   // drive setpoints
   output logic [26:0] chain_speed_set,
   output logic jog_active,
   output logic foil_run,
   output logic signed [27:0] foil_offset_eff,
   output logic signed [27:0] seal_offset_eff
);
   import icp_pkg::*;

   localparam logic [31:0] CYC_PER_S = 32'(CYC_PER_MS * S_IN_MS);
   localparam logic [14:0] MS_LAST = 15'(CYC_PER_MS - 1);

   function automatic logic [4:0] cam_dec(input logic [7:0] a);
      cam_dec = {(a[7:6] == CAM_REGION) && (a[1:0] == 2'h0) && (a[3:2] != 2'h3), a[5:4], a[3:2]};
   endfunction

   // configuration registers
   logic jog_cmd;
   logic [6:0] pusher_num;
   logic [23:0] chain_div;
   logic [13:0] pusher_width;
   logic [26:0] sensor_dist;
   logic [6:0] jog_pct;
   logic [6:0] jog_ramp;
   logic [26:0] max_speed;
   logic signed [17:0] prod_offset;
   logic [26:0] foil_offset;
   logic [26:0] seal_offset;
   icp_cam_cfg_t cam_cfg [NUM_CAMS];

   // tracking state
   logic [NUM_PINS-1:0] sync1, sync2, sync3, pin_st, pin_prev;
   logic synced;
   logic [6:0] vcount;
   logic [23:0] pos;
   logic [24:0] acc;
   logic [11:0] angle;
   logic [14:0] ms_cnt;
   logic [11:0] ang_cnt;
   logic [11:0] rate;
   logic [13:0] push_dist;
   logic prod_busy;
   logic [26:0] prod_dist;
   logic [31:0] ramp_acc;

   // three-stage input synchronisers; a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               sync3[i] <= 1'b0;
               pin_st[i] <= 1'b0;
               pin_prev[i] <= 1'b0;
            end else begin
               sync1[i] <= (i == PIN_STEP) ? enc_step_pin : (i == PIN_PUSHER) ? pusher_pin :
                           (i == PIN_PRODUCT) ? product_pin : ctrl_en_pin;
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
               if (sync2[i] == sync3[i]) begin
                  pin_st[i] <= sync3[i];
               end
               pin_prev[i] <= pin_st[i];
            end
         end
      end
   endgenerate

   wire logic [NUM_PINS-1:0] pin_rise = pin_st & ~pin_prev;
   wire logic step = pin_rise[PIN_STEP];
   wire logic push_edge = pin_rise[PIN_PUSHER];
   wire logic prod_edge = pin_rise[PIN_PRODUCT];
   wire logic enabled = pin_st[PIN_ENABLE];

   // apb decode
   wire logic [4:0] cdec = cam_dec(paddr);
   wire logic wr_en = psel & penable & pready & pwrite;
   wire logic setup = psel & ~penable;
   wire logic ro_hit = (paddr == ADDR_FOIL_EFF) || (paddr == ADDR_SEAL_EFF) || (paddr == ADDR_STATUS) ||
                       (paddr == ADDR_SPEED) || (paddr == ADDR_RATE);
   wire logic rw_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_PUSHER_NUM) || (paddr == ADDR_CHAIN_DIV) ||
                       (paddr == ADDR_PUSHER_WIDTH) || (paddr == ADDR_SENSOR_DIST) ||
                       (paddr == ADDR_JOG_SPEED) || (paddr == ADDR_JOG_RAMP) || (paddr == ADDR_MAX_SPEED) ||
                       (paddr == ADDR_PROD_OFFSET) || (paddr == ADDR_FOIL_OFFSET) ||
                       (paddr == ADDR_SEAL_OFFSET);
   wire logic mapped = ro_hit | rw_hit | cdec[4];
   wire icp_cam_cfg_t rd_cam = cam_cfg[cdec[3:2]];
   wire logic [31:0] rd_cam_word = (cdec[1:0] == CAM_FLD_ON) ? {20'h00000, rd_cam.on} :
                                   (cdec[1:0] == CAM_FLD_OFF) ? {20'h00000, rd_cam.off} :
                                   {22'h000000, rd_cam.delay};
   wire logic [31:0] rd_data =
      cdec[4] ? rd_cam_word :
      (paddr == ADDR_CTRL) ? {31'h00000000, jog_cmd} :
      (paddr == ADDR_PUSHER_NUM) ? {25'h0000000, pusher_num} :
      (paddr == ADDR_CHAIN_DIV) ? {8'h00, chain_div} :
      (paddr == ADDR_PUSHER_WIDTH) ? {18'h00000, pusher_width} :
      (paddr == ADDR_SENSOR_DIST) ? {5'h00, sensor_dist} :
      (paddr == ADDR_JOG_SPEED) ? {25'h0000000, jog_pct} :
      (paddr == ADDR_JOG_RAMP) ? {25'h0000000, jog_ramp} :
      (paddr == ADDR_MAX_SPEED) ? {5'h00, max_speed} :
      (paddr == ADDR_PROD_OFFSET) ? 32'(prod_offset) :
      (paddr == ADDR_FOIL_OFFSET) ? {5'h00, foil_offset} :
      (paddr == ADDR_SEAL_OFFSET) ? {5'h00, seal_offset} :
      (paddr == ADDR_FOIL_EFF) ? 32'(foil_offset_eff) :
      (paddr == ADDR_SEAL_EFF) ? 32'(seal_offset_eff) :
      (paddr == ADDR_STATUS) ? {11'h000, enabled, synced, vcount, angle} :
      (paddr == ADDR_SPEED) ? {5'h00, chain_speed_set} :
      (paddr == ADDR_RATE) ? {20'h00000, rate} : 32'h00000000;

   // one wait-free access phase: pready rises in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? rd_data : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         jog_cmd <= 1'b0;
         pusher_num <= RST_PUSHER_NUM;
         chain_div <= RST_CHAIN_DIV;
         pusher_width <= RST_PUSHER_WIDTH;
         sensor_dist <= RST_SENSOR_DIST;
         jog_pct <= RST_JOG_PCT;
         jog_ramp <= RST_JOG_RAMP;
         max_speed <= RST_MAX_SPEED;
         prod_offset <= 18'sh00000;
         foil_offset <= 27'h0000000;
         seal_offset <= 27'h0000000;
      end else if (wr_en) begin
         if (paddr == ADDR_CTRL) jog_cmd <= pwdata[0];
         if (paddr == ADDR_PUSHER_NUM) pusher_num <= pwdata[6:0];
         if (paddr == ADDR_CHAIN_DIV) chain_div <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
         if (paddr == ADDR_PUSHER_WIDTH) pusher_width <= pwdata[13:0];
         if (paddr == ADDR_SENSOR_DIST) sensor_dist <= pwdata[26:0];
         // percent above full scale is held at full scale
         if (paddr == ADDR_JOG_SPEED) jog_pct <= (pwdata[6:0] > PCT_FULL) ? PCT_FULL : pwdata[6:0];
         if (paddr == ADDR_JOG_RAMP) jog_ramp <= pwdata[6:0];
         if (paddr == ADDR_MAX_SPEED) max_speed <= pwdata[26:0];
         if (paddr == ADDR_PROD_OFFSET) prod_offset <= pwdata[17:0];
         if (paddr == ADDR_FOIL_OFFSET) foil_offset <= pwdata[26:0];
         if (paddr == ADDR_SEAL_OFFSET) seal_offset <= pwdata[26:0];
      end
   end

   generate
      for (genvar c = 0; c < NUM_CAMS; c++) begin : g_camreg
         wire logic cam_wr = wr_en & cdec[4] & (cdec[3:2] == 2'(c));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cam_cfg[c] <= '0;
            end else if (cam_wr) begin
               if (cdec[1:0] == CAM_FLD_ON) cam_cfg[c].on <= pwdata[11:0];
               if (cdec[1:0] == CAM_FLD_OFF) cam_cfg[c].off <= pwdata[11:0];
               if (cdec[1:0] == CAM_FLD_DLY) cam_cfg[c].delay <= pwdata[9:0];
            end
         end
         icp_cam u_cam (
            .pclk(pclk),
            .presetn(presetn),
            .angle(angle),
            .rate(rate),
            .cfg(cam_cfg[c]),
            .cam(cam_out[c])
         );
      end
   endgenerate

   // index selection by pusher number
   wire logic mode_virtual = (pusher_num == 7'h00);
   wire logic mode_every = (pusher_num == 7'h01);
   wire logic [6:0] n_minus1 = pusher_num - 7'h01;
   wire logic phys_take = push_edge & enabled &
                          (~synced | mode_every | (~mode_virtual & (vcount >= n_minus1)));
   wire logic pos_wrap = step & ((pos + 24'h000001) >= chain_div);
   wire logic virt_fire = pos_wrap & synced & enabled & ~phys_take &
                          (mode_virtual | (~mode_every & (vcount < n_minus1)));
   wire logic index_now = phys_take | virt_fire;
   // division wrap zeroes the angle even without an index, so the angle stays modulo one division
   wire logic angle_clr = index_now | pos_wrap;

   // angle in tenths of a degree: distance times 3600 over the division, stepped without a divider
   wire logic [24:0] acc_add = step ? {13'h0000, ANGLE_FULL} : 25'h0000000;
   wire logic ang_inc = (acc >= {1'b0, chain_div});
   wire logic [24:0] next_acc = acc + acc_add - (ang_inc ? {1'b0, chain_div} : 25'h0000000);
   wire logic [11:0] next_angle = (angle >= ANGLE_FULL - 12'h001) ? 12'h000 : angle + 12'h001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         synced <= 1'b0;
         vcount <= 7'h00;
         pos <= 24'h000000;
         acc <= 25'h0000000;
         angle <= 12'h000;
         index_pulse <= 1'b0;
         virtual_index <= 1'b0;
      end else begin
         index_pulse <= index_now;
         virtual_index <= virt_fire;
         if (!enabled) begin
            synced <= 1'b0; // a new enable takes a fresh first pusher
         end else if (phys_take) begin
            synced <= 1'b1;
         end
         if (phys_take) begin
            vcount <= 7'h00;
         end else if (virt_fire) begin
            vcount <= vcount + 7'h01;
         end
         // zero degrees at the pusher front edge: a physical index clears the angle
         if (angle_clr) begin
            pos <= 24'h000000;
            acc <= 25'h0000000;
            angle <= 12'h000;
         end else begin
            pos <= step ? pos + 24'h000001 : pos;
            acc <= next_acc;
            angle <= ang_inc ? next_angle : angle;
         end
      end
   end

   // angle rate over a 1 ms window, used for the cam anticipation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= 15'h0000;
         ang_cnt <= 12'h000;
         rate <= 12'h000;
      end else if (ms_cnt >= MS_LAST) begin
         ms_cnt <= 15'h0000;
         ang_cnt <= 12'h000;
         rate <= ang_cnt;
      end else begin
         ms_cnt <= ms_cnt + 15'h0001;
         if (ang_inc && !angle_clr && ang_cnt != RATE_MAX) ang_cnt <= ang_cnt + 12'h001;
      end
   end

   // product detection blanked over the pusher width; hand-over after the sensor distance
   wire logic blanked = (push_dist < pusher_width);
   wire logic prod_ok = prod_edge & ~blanked & ~push_edge;
   wire logic at_handoff = prod_busy & (prod_dist >= sensor_dist);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         push_dist <= 14'h3FFF;
         prod_busy <= 1'b0;
         prod_dist <= 27'h0000000;
         product_detect <= 1'b0;
         handoff_pulse <= 1'b0;
      end else begin
         if (push_edge) begin
            push_dist <= 14'h0000;
         end else if (step && push_dist != 14'h3FFF) begin
            push_dist <= push_dist + 14'h0001;
         end
         product_detect <= prod_ok;
         handoff_pulse <= at_handoff;
         // a later product restarts the distance; one product in flight is tracked
         if (prod_ok) begin
            prod_busy <= 1'b1;
            prod_dist <= 27'h0000000;
         end else if (at_handoff) begin
            prod_busy <= 1'b0;
         end else if (prod_busy && step) begin
            prod_dist <= prod_dist + 27'h0000001;
         end
      end
   end

   // jog: chain only, ramped towards a share of maximum speed
   wire logic [33:0] jog_prod = max_speed * jog_pct;
   wire logic [26:0] jog_target = jog_cmd ? 27'(jog_prod / 34'(PCT_FULL)) : 27'h0000000;
   wire logic [31:0] ramp_cycles = 32'(jog_ramp) * CYC_PER_S;
   wire logic [32:0] ramp_sum = {1'b0, ramp_acc} + {6'h00, max_speed};
   wire logic ramp_step = (ramp_sum >= {1'b0, ramp_cycles});
   wire logic at_target = (chain_speed_set == jog_target);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_acc <= 32'h00000000;
         chain_speed_set <= 27'h0000000;
         jog_active <= 1'b0;
         foil_run <= 1'b0;
         foil_offset_eff <= 28'sh0000000;
         seal_offset_eff <= 28'sh0000000;
      end else begin
         // one unit per step: max speed over the ramp time gives the full 0 to 100 percent slope
         if (jog_ramp == 7'h00) begin
            ramp_acc <= 32'h00000000;
            chain_speed_set <= jog_target;
         end else if (at_target) begin
            ramp_acc <= 32'h00000000;
         end else if (ramp_step) begin
            ramp_acc <= 32'(ramp_sum - {1'b0, ramp_cycles});
            chain_speed_set <= (chain_speed_set < jog_target) ? chain_speed_set + 27'h0000001
                                                              : chain_speed_set - 27'h0000001;
         end else begin
            ramp_acc <= ramp_sum[31:0];
         end
         jog_active <= jog_cmd | (chain_speed_set != 27'h0000000);
         foil_run <= enabled & ~jog_cmd & (chain_speed_set == 27'h0000000);
         foil_offset_eff <= $signed({1'b0, foil_offset}) + 28'(prod_offset);
         seal_offset_eff <= $signed({1'b0, seal_offset}) + 28'(prod_offset);
      end
   end

endmodule

// [common/icp_pkg.sv]
package icp_pkg;

   // clock and time base
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned MS_IN_NS = 1000000;
   localparam int unsigned S_IN_MS = 1000;
   localparam int unsigned CYC_PER_MS_DEF = MS_IN_NS / CLK_PERIOD_NS;

   // one chain division in tenths of a degree
   localparam logic [11:0] ANGLE_FULL = 12'hE10;
   localparam logic [11:0] RATE_MAX = 12'hFFF;
   localparam logic [6:0] PCT_FULL = 7'h64;
   localparam int unsigned NUM_CAMS = 4;
   localparam int unsigned NUM_PINS = 4;

   // pin positions in the synchroniser vector
   localparam int unsigned PIN_STEP = 0;
   localparam int unsigned PIN_PUSHER = 1;
   localparam int unsigned PIN_PRODUCT = 2;
   localparam int unsigned PIN_ENABLE = 3;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PUSHER_NUM = 8'h04;
   localparam logic [7:0] ADDR_CHAIN_DIV = 8'h08;
   localparam logic [7:0] ADDR_PUSHER_WIDTH = 8'h0C;
   localparam logic [7:0] ADDR_SENSOR_DIST = 8'h10;
   localparam logic [7:0] ADDR_JOG_SPEED = 8'h14;
   localparam logic [7:0] ADDR_JOG_RAMP = 8'h18;
   localparam logic [7:0] ADDR_MAX_SPEED = 8'h1C;
   localparam logic [7:0] ADDR_PROD_OFFSET = 8'h20;
   localparam logic [7:0] ADDR_FOIL_OFFSET = 8'h24;
   localparam logic [7:0] ADDR_SEAL_OFFSET = 8'h28;
   localparam logic [7:0] ADDR_FOIL_EFF = 8'h2C;
   localparam logic [7:0] ADDR_SEAL_EFF = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h34;
   localparam logic [7:0] ADDR_SPEED = 8'h38;
   localparam logic [7:0] ADDR_RATE = 8'h3C;
   // cams: base 0x40, stride 0x10, fields on/off/delay at +0/+4/+8
   localparam logic [1:0] CAM_REGION = 2'h1;
   localparam logic [1:0] CAM_FLD_ON = 2'h0;
   localparam logic [1:0] CAM_FLD_OFF = 2'h1;
   localparam logic [1:0] CAM_FLD_DLY = 2'h2;

   // reset values
   localparam logic [6:0] RST_PUSHER_NUM = 7'h01;
   localparam logic [23:0] RST_CHAIN_DIV = 24'h000E10;
   localparam logic [13:0] RST_PUSHER_WIDTH = 14'h0001;
   localparam logic [26:0] RST_SENSOR_DIST = 27'h0000000;
   localparam logic [6:0] RST_JOG_PCT = 7'h00;
   localparam logic [6:0] RST_JOG_RAMP = 7'h00;
   localparam logic [26:0] RST_MAX_SPEED = 27'h0000000;

   typedef struct packed {
      logic [11:0] on;
      logic [11:0] off;
      logic [9:0] delay;
   } icp_cam_cfg_t;

endpackage

// [design/icp_cam.sv]
module icp_cam (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // chain angle and its rate in tenths of a degree per ms
   input wire logic [11:0] angle,
   input wire logic [11:0] rate,
   // window and anticipation
   input wire icp_pkg::icp_cam_cfg_t cfg,
   // actuator output
   output logic cam
);
   import icp_pkg::*;

   wire logic [21:0] lead_raw;
   wire logic [11:0] lead;
   wire logic [12:0] look_sum;
   wire logic [11:0] look;
   wire logic in_win;

   // anticipation: look ahead by the angle travelled during the delay time
   assign lead_raw = cfg.delay * rate;
   assign lead = 12'(lead_raw % 22'(ANGLE_FULL));
   assign look_sum = {1'b0, angle} + {1'b0, lead};
   assign look = (look_sum >= 13'(ANGLE_FULL)) ? 12'(look_sum - 13'(ANGLE_FULL)) : look_sum[11:0];

   // off below on wraps through zero; equal points give an output that never switches on
   assign in_win = (cfg.on <= cfg.off) ? (look >= cfg.on && look < cfg.off)
                                       : (look >= cfg.on || look < cfg.off);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cam <= 1'b0;
      end else begin
         cam <= in_win;
      end
   end

endmodule

// [tb/icp_chain_properties.sv]
module icp_chain_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // outputs watched
   input wire logic index_pulse,
   input wire logic virtual_index,
   input wire logic [26:0] chain_speed_set,
   input wire logic jog_active,
   input wire logic foil_run,
   input wire logic signed [27:0] foil_offset_eff
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_answer_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   ready_single_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
   virt_index_a: assert property (virtual_index |-> index_pulse) else $error("virtual index lost");
   // steps arrive at most every six clocks, so two indexes never sit close
   index_gap_a: assert property (index_pulse |=> !index_pulse [*4]) else $error("index too close");
   offset_write_a: assert property ($changed(foil_offset_eff) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("foil offset moved without a write");
   jog_excl_a: assert property (jog_active |-> !foil_run) else $error("foil runs during jog");
   jog_zero_a: assert property (!jog_active |-> chain_speed_set == 27'h0) else $error("speed without jog");
   cover property (virtual_index);
   cover property (pslverr);
   cover property (jog_active && chain_speed_set != 27'h0);
endmodule

bind icp_chain_top icp_chain_properties u_icp_chain_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .index_pulse(index_pulse), .virtual_index(virtual_index), .chain_speed_set(chain_speed_set),
   .jog_active(jog_active), .foil_run(foil_run), .foil_offset_eff(foil_offset_eff));

// [tb/icp_machine_model.sv]
module icp_machine_model #(
   parameter int PITCH = 1200,
   parameter int OFS = 100,
   parameter int STEP_CYC = 6
) (
   // clock and motion command
   input wire logic pclk,
   input wire logic run,
   // sensor pins and true chain position
   output logic enc_step_pin,
   output logic pusher_pin,
   output int pos
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph = STEP_CYC - 1;
   int hold = 0;
   initial begin
      enc_step_pin = 0;
      pusher_pin = 0;
      pos = 0;
   end
   // encoder stands still while stopped; a pusher passes every pitch at OFS
   always @(posedge pclk) begin
      if (run) begin
         ph = (ph + 1) % STEP_CYC;
         enc_step_pin <= (ph < STEP_CYC / 2);
         if (ph == 0) begin
            pos <= pos + 1;
            if ((pos + 1) % PITCH == OFS) hold = 2 * STEP_CYC;
         end
      end
      if (hold > 0) hold = hold - 1;
      pusher_pin <= (hold > 0);
   end
endmodule

// [tb/icp_chain_top_tb.sv]
module icp_chain_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import icp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, product_pin = 0, ctrl_en_pin = 0, run = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, index_pulse, virtual_index, product_detect, handoff_pulse;
   logic enc_step_pin, pusher_pin, jog_active, foil_run;
   logic [3:0] cam_out;
   logic [26:0] chain_speed_set;
   logic signed [27:0] foil_offset_eff, seal_offset_eff;
   int pos, n_errors = 0, total_checks = 0, n_idx = 0, n_virt = 0, n_prod = 0, n_hand = 0, i0, v0, p0, h0;
   int ons[3] = '{0, 3000, 1800};
   int offs[3] = '{1800, 600, 2400};
   int dly[3] = '{0, 0, 10};
   int po[2] = '{-99999, 99999};

   icp_chain_top #(.CYC_PER_MS(50)) u_icp_chain_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enc_step_pin(enc_step_pin), .pusher_pin(pusher_pin), .product_pin(product_pin), .ctrl_en_pin(ctrl_en_pin),
      .cam_out(cam_out), .index_pulse(index_pulse), .virtual_index(virtual_index), .product_detect(product_detect),
      .handoff_pulse(handoff_pulse), .chain_speed_set(chain_speed_set), .jog_active(jog_active),
      .foil_run(foil_run), .foil_offset_eff(foil_offset_eff), .seal_offset_eff(seal_offset_eff));
   icp_machine_model u_icp_machine_model (.pclk(pclk), .run(run), .enc_step_pin(enc_step_pin),
      .pusher_pin(pusher_pin), .pos(pos));

   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      n_idx += (index_pulse === 1'b1);
      n_virt += (virtual_index === 1'b1);
      n_prod += (product_detect === 1'b1);
      n_hand += (handoff_pulse === 1'b1);
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 16) begin
         chk("apb answer", 1, 0);
         print_verdict();
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(a, 0, 32'h0);
      chk(what, exp, rd);
   endtask
   // the 12 extra clocks cover the pin synchroniser and one further step
   task automatic to_pos(input int p);
      int k;
      k = 0;
      while (pos < p && k < 80000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 80000) begin
         chk("position wait", 1, 0);
         print_verdict();
      end
      repeat (12) @(posedge pclk);
   endtask
   task automatic product(input string what, input int exp_n);
      p0 = n_prod;
      product_pin <= 1;
      repeat (6) @(posedge pclk);
      product_pin <= 0;
      repeat (8) @(posedge pclk);
      chk(what, 32'(p0 + exp_n), 32'(n_prod));
   endtask
   task automatic mode(input logic [31:0] n);
      ctrl_en_pin <= 0;
      wr_reg(ADDR_PUSHER_NUM, n);
      repeat (4) @(posedge pclk);
      ctrl_en_pin <= 1;
      i0 = n_idx;
      v0 = n_virt;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1, d);
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      rdchk("pusher num", ADDR_PUSHER_NUM, 32'(RST_PUSHER_NUM));
      rdchk("chain div", ADDR_CHAIN_DIV, 32'(RST_CHAIN_DIV));
      rdchk("unmapped", 8'hFC, 32'h0);
      chk("unmapped err", 1, 32'(err));
      wr_reg(ADDR_FOIL_OFFSET, 32'd100);
      wr_reg(ADDR_SEAL_OFFSET, 32'd200);
      for (int i = 0; i < 2; i++) begin
         wr_reg(ADDR_PROD_OFFSET, po[i]);
         repeat (2) @(posedge pclk);
         chk("foil eff", 32'(100 + po[i]), 32'(foil_offset_eff));
         chk("seal eff", 32'(200 + po[i]), 32'(seal_offset_eff));
         rdchk("prod offset", ADDR_PROD_OFFSET, po[i]);
      end
      ctrl_en_pin <= 1;
      wr_reg(ADDR_MAX_SPEED, 32'd10000);
      wr_reg(ADDR_JOG_SPEED, 32'd1);
      wr_reg(ADDR_CTRL, 32'd1);
      repeat (4) @(posedge pclk);
      chk("jog speed", 32'd100, 32'(chain_speed_set));
      chk("foil in jog", 0, 32'(foil_run));
      chk("jog active", 1, 32'(jog_active));
      wr_reg(ADDR_CTRL, 32'd0);
      repeat (4) @(posedge pclk);
      chk("jog stop", 0, 32'(chain_speed_set));
      chk("foil after jog", 1, 32'(foil_run));
      chk("jog idle", 0, 32'(jog_active));
      wr_reg(ADDR_JOG_RAMP, 32'd1);
      wr_reg(ADDR_CTRL, 32'd1);
      repeat (250) @(posedge pclk);
      chk("ramp half", 1, 32'(chain_speed_set > 30 && chain_speed_set < 70));
      repeat (400) @(posedge pclk);
      chk("ramp full", 32'd100, 32'(chain_speed_set));
      wr_reg(ADDR_CTRL, 32'd0);
      wr_reg(ADDR_JOG_RAMP, 32'd0);
      wr_reg(ADDR_CHAIN_DIV, 32'd1200);
      wr_reg(ADDR_PUSHER_WIDTH, 32'd50);
      wr_reg(ADDR_SENSOR_DIST, 32'd20);
      for (int c = 0; c < 3; c++) begin
         wr_reg(8'h40 + 8'(c * 16), ons[c]);
         wr_reg(8'h44 + 8'(c * 16), offs[c]);
         wr_reg(8'h48 + 8'(c * 16), dly[c]);
      end
      i0 = n_idx;
      v0 = n_virt;
      run <= 1;
      to_pos(1320);
      product("product in pusher", 0);
      to_pos(1600);
      chk("cams 900", 32'h1, 32'(cam_out));
      product("product", 1);
      h0 = n_hand;
      to_pos(1630);
      chk("handoff", 32'(h0 + 1), 32'(n_hand));
      to_pos(1867);
      chk("cams 1700", 32'h5, 32'(cam_out));
      to_pos(2067);
      chk("cams 2300", 32'h0, 32'(cam_out));
      to_pos(2400);
      chk("cams 3300", 32'h2, 32'(cam_out));
      to_pos(3100);
      chk("mode 1 index", 32'd3, 32'(n_idx - i0));
      chk("mode 1 virtual", 32'd0, 32'(n_virt - v0));
      mode(32'd0);
      to_pos(6700);
      chk("mode 0 index", 32'd3, 32'(n_idx - i0));
      chk("mode 0 virtual", 32'd2, 32'(n_virt - v0));
      mode(32'd3);
      to_pos(11500);
      chk("mode 3 index", 32'd4, 32'(n_idx - i0));
      chk("mode 3 virtual", 32'd2, 32'(n_virt - v0));
      print_verdict();
   end
endmodule
